// File: rtl/insn_decode_pkg.sv
// constants and types shared by the instruction format decoder
// Notes on behaviour
// - an instruction word is 24 bits; top 8 bits pick the type
// - only three instruction types span two consecutive program words
// - every instruction falls in one of five groups
// - register word/byte ops yield base source, modifiable source, destination
// - file register ops yield file address and destination selector
// - bit ops yield a target and a bit position, literal or register
// - literal moves yield the literal and its target register or file
// - literal arithmetic yields base source, literal, optional destination
// - multiply-accumulate ops yield accumulator, sources, prefetches, write-back
// - other signal ops yield accumulator, operand, shift by register or literal
// - second word has zero top byte and alone acts as no-operation
// - two-word instructions take two instruction cycles
// - taken branches or true tests add one no-operation cycle; the decoder adds it to every branch opcode, taken or not
`default_nettype none
package insn_decode_pkg;
	localparam int WORD_W = 24;
	localparam int OP_MSB = 23;
	localparam int OP_LSB = 16;
	localparam int REG_W = 4;
	localparam int MODE_W = 3;
	// field positions within a single word
	localparam int BASE_LSB = 15;
	localparam int DEST_MODE_LSB = 11;
	localparam int DEST_LSB = 7;
	localparam int SRC_MODE_LSB = 4;
	localparam int SRC_LSB = 0;
	localparam int FILE_W = 13;
	localparam int FILE_LSB = 0;
	localparam int FILE_DEST_BIT = 13;
	localparam int BITPOS_LSB = 12;
	localparam int LIT_W = 16;
	localparam int LIT_LSB = 4;
	localparam int ACC_BIT = 15;
	localparam int SHIFT_LSB = 7;
	localparam int SHIFT_W = 6;
	localparam int MULSEL_LSB = 12;
	localparam int XPF_LSB = 6;
	localparam int YPF_LSB = 2;
	localparam int AWB_LSB = 0;
	// opcode ranges that select a class
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_CTRL_HI = 8'h1f;
	localparam logic [7:0] OP_LIT_MOV_LO = 8'h20;
	localparam logic [7:0] OP_LIT_HI = 8'h3f;
	localparam logic [7:0] OP_WORD_HI = 8'h7f;
	localparam logic [7:0] OP_BIT_HI = 8'haf;
	localparam logic [7:0] OP_MAC_LO = 8'hc0;
	localparam logic [7:0] OP_MAC_HI = 8'hc7;
	localparam logic [7:0] OP_DSP_HI = 8'hcf;
	localparam logic [7:0] OP_FILE_LO = 8'hb0;
	localparam logic [7:0] OP_FILE_HI = 8'hbf;
	localparam logic [7:0] OP_LITMOV_HI = 8'h2f;
	// the three two-word types
	localparam logic [7:0] OP_GOTO = 8'h04;
	localparam logic [7:0] OP_CALL = 8'h02;
	localparam logic [7:0] OP_DO = 8'h08;
	// control opcodes that change the program counter or test and skip
	localparam logic [7:0] OP_BRA_LO = 8'h30;
	localparam logic [7:0] OP_BRA_HI = 8'h37;
	localparam logic [7:0] OP_SKIP_LO = 8'ha4;
	localparam logic [7:0] OP_SKIP_HI = 8'ha7;
	localparam logic [1:0] SINGLE_CYCLES = 2'h1;
	localparam logic [1:0] LONG_CYCLES = 2'h2;

	typedef enum logic [4:0] {
		CLS_WORD = 5'h01,
		CLS_BIT = 5'h02,
		CLS_LIT = 5'h04,
		CLS_DSP = 5'h08,
		CLS_CTRL = 5'h10
	} insn_class_t;

	typedef enum logic [1:0] {
		ST_FIRST = 2'h1,
		ST_SECOND = 2'h2
	} word_state_t;
endpackage
`default_nettype wire

// File: rtl/insn_class_sort.sv
// opcode classifier: class, two-word marker and base cycle count
`default_nettype none
module insn_class_sort
	import insn_decode_pkg::*;
(
	// opcode in
	input wire logic [7:0] opcode,
	input wire logic cond_true,
	// classification out
	output insn_decode_pkg::insn_class_t insn_class,
	output logic two_word,
	output logic file_form,
	output logic lit_move,
	output logic mac_form,
	output logic [1:0] cycles
);
	wire logic is_ctrl = opcode <= OP_CTRL_HI;
	wire logic is_lit = opcode >= OP_LIT_MOV_LO && opcode <= OP_LIT_HI;
	wire logic is_word = opcode > OP_LIT_HI && opcode <= OP_WORD_HI;
	wire logic is_bit = opcode > OP_WORD_HI && opcode <= OP_BIT_HI;
	wire logic is_file = opcode >= OP_FILE_LO && opcode <= OP_FILE_HI;
	wire logic is_dsp = opcode >= OP_MAC_LO && opcode <= OP_DSP_HI;
	wire logic is_pcchg = (opcode >= OP_BRA_LO && opcode <= OP_BRA_HI);
	wire logic is_skip = opcode >= OP_SKIP_LO && opcode <= OP_SKIP_HI;

	// one of five groups; file forms count as word/byte ops
	assign insn_class = is_ctrl ? CLS_CTRL :
		is_lit ? CLS_LIT :
		(is_word || is_file) ? CLS_WORD :
		is_bit ? CLS_BIT :
		is_dsp ? CLS_DSP : CLS_CTRL;
	// exactly three types are two words long
	assign two_word = opcode == OP_GOTO || opcode == OP_CALL ||
		opcode == OP_DO;
	assign file_form = is_file;
	assign lit_move = is_lit && opcode <= OP_LITMOV_HI;
	assign mac_form = opcode >= OP_MAC_LO && opcode <= OP_MAC_HI;
	// branches and true tests cost one extra no-operation cycle
	assign cycles = (two_word || is_pcchg || (is_skip && cond_true)) ?
		LONG_CYCLES : SINGLE_CYCLES;
endmodule
`default_nettype wire

// File: rtl/insn_field_split.sv
// operand field extraction from one instruction word
`default_nettype none
module insn_field_split
	import insn_decode_pkg::*;
(
	// word in
	input wire logic [23:0] word,
	// register operands
	output logic [3:0] base_source_reg,
	output logic [3:0] modifiable_source_reg,
	output logic [2:0] source_mode,
	output logic [3:0] result_dest_reg,
	output logic [2:0] dest_mode,
	// file, literal and bit operands
	output logic [12:0] file_addr,
	output logic dest_is_file,
	output logic [15:0] literal,
	output logic [3:0] bit_pos,
	// signal processing operands
	output logic acc_sel,
	output logic [3:0] mul_pair,
	output logic [3:0] x_prefetch,
	output logic [3:0] y_prefetch,
	output logic [1:0] acc_writeback,
	output logic [5:0] shift_amount,
	output logic [3:0] shift_count_reg
);
	// fields overlap by design; the class tells the consumer which apply
	assign base_source_reg = word[BASE_LSB+:REG_W];
	assign modifiable_source_reg = word[SRC_LSB+:REG_W];
	assign source_mode = word[SRC_MODE_LSB+:MODE_W];
	assign result_dest_reg = word[DEST_LSB+:REG_W];
	assign dest_mode = word[DEST_MODE_LSB+:MODE_W];
	assign file_addr = word[FILE_LSB+:FILE_W];
	assign dest_is_file = word[FILE_DEST_BIT];
	assign literal = word[LIT_LSB+:LIT_W];
	assign bit_pos = word[BITPOS_LSB+:REG_W];
	assign acc_sel = word[ACC_BIT];
	assign mul_pair = word[MULSEL_LSB+:4];
	assign x_prefetch = word[XPF_LSB+:4];
	assign y_prefetch = word[YPF_LSB+:4];
	assign acc_writeback = word[AWB_LSB+:2];
	assign shift_amount = word[SHIFT_LSB+:SHIFT_W];
	assign shift_count_reg = word[SRC_LSB+:REG_W];
endmodule
`default_nettype wire

// File: rtl/insn_format_decode.sv
// top level instruction format decoder facing the fetch stage
`default_nettype none
module insn_format_decode
	import insn_decode_pkg::*;
#(
	parameter int WORD_WIDTH = 24
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// fetch side
	input wire logic word_valid,
	input wire logic [23:0] word_in,
	input wire logic cond_true,
	// execution side
	output logic dec_valid,
	output insn_decode_pkg::insn_class_t insn_class,
	output logic is_nop,
	output logic is_two_word,
	output logic second_word_valid,
	output logic [23:0] second_word,
	output logic [1:0] exec_cycles,
	output logic [3:0] base_source_reg,
	output logic [3:0] modifiable_source_reg,
	output logic [2:0] source_mode,
	output logic [3:0] result_dest_reg,
	output logic [2:0] dest_mode,
	output logic [12:0] file_addr,
	output logic dest_is_file,
	output logic dest_is_work_zero,
	output logic [15:0] literal,
	output logic [3:0] bit_pos,
	output logic bit_pos_from_reg,
	output logic acc_sel,
	output logic [3:0] mul_pair,
	output logic [3:0] x_prefetch,
	output logic [3:0] y_prefetch,
	output logic [1:0] acc_writeback,
	output logic [5:0] shift_amount,
	output logic [3:0] shift_count_reg
);
	// the field map is fixed, so only the documented word width is served
	if (WORD_WIDTH != WORD_W) begin : g_bad_width
		$error("word width must be 24");
	end

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// ---------------------------------------------------------------
	// classification and field split
	// ---------------------------------------------------------------
	word_state_t state;
	word_state_t next_state;
	insn_class_t cls;
	logic two_w;
	logic file_f;
	logic lit_mv;
	logic mac_f;
	logic [1:0] cyc;
	logic [3:0] f_base;
	logic [3:0] f_src;
	logic [2:0] f_smode;
	logic [3:0] f_dst;
	logic [2:0] f_dmode;
	logic [12:0] f_file;
	logic f_dfile;
	logic [15:0] f_lit;
	logic [3:0] f_bit;
	logic f_acc;
	logic [3:0] f_mul;
	logic [3:0] f_xpf;
	logic [3:0] f_ypf;
	logic [1:0] f_awb;
	logic [5:0] f_shift;
	logic [3:0] f_shreg;

	// type lives in the top byte of the 24-bit word
	wire logic [7:0] opcode = word_in[OP_MSB:OP_LSB];

	insn_class_sort u_sort (
		.opcode(opcode),
		.cond_true(cond_true),
		.insn_class(cls),
		.two_word(two_w),
		.file_form(file_f),
		.lit_move(lit_mv),
		.mac_form(mac_f),
		.cycles(cyc)
	);

	insn_field_split u_split (
		.word(word_in),
		.base_source_reg(f_base),
		.modifiable_source_reg(f_src),
		.source_mode(f_smode),
		.result_dest_reg(f_dst),
		.dest_mode(f_dmode),
		.file_addr(f_file),
		.dest_is_file(f_dfile),
		.literal(f_lit),
		.bit_pos(f_bit),
		.acc_sel(f_acc),
		.mul_pair(f_mul),
		.x_prefetch(f_xpf),
		.y_prefetch(f_ypf),
		.acc_writeback(f_awb),
		.shift_amount(f_shift),
		.shift_count_reg(f_shreg)
	);

	wire logic in_second = state == ST_SECOND;
	// nothing is taken until the released reset has passed both flops
	wire logic take_first = word_valid && rst_sync && !in_second;
	wire logic take_second = word_valid && rst_sync && in_second;
	// a lone word with zero top byte decodes as no-operation
	wire logic lone_nop = opcode == OP_NOP;
	// bit position comes from the base register in register bit forms
	wire logic pos_reg = cls == CLS_BIT && word_in[SRC_MODE_LSB+2];
	// non-multiplying dsp shift comes from a register when mode bit set
	wire logic shift_by_reg = cls == CLS_DSP && !mac_f && f_smode[0];

	// ---------------------------------------------------------------
	// two-word tracking
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_FIRST: begin
				if (take_first && two_w)
					next_state = ST_SECOND;
			end
			ST_SECOND: begin
				if (take_second)
					next_state = ST_FIRST;
			end
			default: begin
				next_state = ST_FIRST;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			state <= ST_FIRST;
		else if (!rst_sync)
			state <= ST_FIRST;
		else
			state <= next_state;
	end

	// ---------------------------------------------------------------
	// registered outputs, all fields in one cycle
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dec_valid <= 1'b0;
			second_word_valid <= 1'b0;
			second_word <= 24'h000000;
		end else begin
			dec_valid <= rst_sync && take_first;
			second_word_valid <= rst_sync && take_second;
			if (take_second)
				second_word <= word_in;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			insn_class <= CLS_CTRL;
			is_nop <= 1'b1;
			is_two_word <= 1'b0;
			exec_cycles <= SINGLE_CYCLES;
		end else if (take_first) begin
			insn_class <= cls;
			is_nop <= lone_nop;
			is_two_word <= two_w;
			exec_cycles <= cyc;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			base_source_reg <= 4'h0;
			modifiable_source_reg <= 4'h0;
			source_mode <= 3'h0;
			result_dest_reg <= 4'h0;
			dest_mode <= 3'h0;
			file_addr <= 13'h0000;
			dest_is_file <= 1'b0;
			dest_is_work_zero <= 1'b0;
			literal <= 16'h0000;
			bit_pos <= 4'h0;
			bit_pos_from_reg <= 1'b0;
		end else if (take_first) begin
			base_source_reg <= f_base;
			modifiable_source_reg <= f_src;
			source_mode <= f_smode;
			result_dest_reg <= f_dst;
			dest_mode <= f_dmode;
			file_addr <= f_file;
			dest_is_file <= file_f && f_dfile;
			dest_is_work_zero <= file_f && !f_dfile;
			// moves carry a wider literal, arithmetic a narrow one
			literal <= lit_mv ? f_lit : {6'h00, f_lit[9:0]};
			bit_pos <= f_bit;
			bit_pos_from_reg <= pos_reg;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			acc_sel <= 1'b0;
			mul_pair <= 4'h0;
			x_prefetch <= 4'h0;
			y_prefetch <= 4'h0;
			acc_writeback <= 2'h0;
			shift_amount <= 6'h00;
			shift_count_reg <= 4'h0;
		end else if (take_first) begin
			acc_sel <= f_acc;
			mul_pair <= mac_f ? f_mul : 4'h0;
			x_prefetch <= mac_f ? f_xpf : 4'h0;
			y_prefetch <= mac_f ? f_ypf : 4'h0;
			acc_writeback <= mac_f ? f_awb : 2'h0;
			shift_amount <= shift_by_reg ? 6'h00 : f_shift;
			shift_count_reg <= shift_by_reg ? f_shreg : 4'h0;
		end
	end
endmodule
`default_nettype wire

// File: sim/insn_format_sva.sv
// assertion checker for the instruction format decoder
`default_nettype none
module insn_format_sva
	import insn_decode_pkg::*;
#(
	parameter int WORD_WIDTH = 24
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// fetch side
	input wire logic word_valid,
	input wire logic [23:0] word_in,
	input wire logic cond_true,
	// execution side
	input wire logic dec_valid,
	input wire insn_decode_pkg::insn_class_t insn_class,
	input wire logic is_nop,
	input wire logic is_two_word,
	input wire logic second_word_valid,
	input wire logic [23:0] second_word,
	input wire logic [1:0] exec_cycles,
	input wire logic [3:0] base_source_reg,
	input wire logic [3:0] modifiable_source_reg,
	input wire logic [3:0] result_dest_reg,
	input wire logic [12:0] file_addr,
	input wire logic dest_is_file,
	input wire logic dest_is_work_zero,
	input wire logic [15:0] literal,
	input wire logic acc_sel,
	input wire logic [1:0] acc_writeback
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// taken word, one cycle late
	// ----
	logic [23:0] w_q;
	logic c_q;
	logic [7:0] op;
	logic two;
	logic [4:0] cls;
	always_ff @(posedge clock) begin
		w_q <= word_in;
		c_q <= cond_true;
	end
	assign op = w_q[23:16];
	assign two = op == OP_CALL || op == OP_GOTO || op == OP_DO;
	// zero marks ranges whose class is left unchecked
	assign cls = op < 8'h20 ? 5'h10 : op < 8'h30 ? 5'h04 :
		op < 8'h40 ? 5'h00 : op < 8'h80 ? 5'h01 : op < 8'hb0 ? 5'h02 :
		op < 8'hc0 ? 5'h01 : op < 8'hd0 ? 5'h08 : 5'h00;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_class;
		dec_valid && cls != 5'h00 |-> insn_class == cls;
	endproperty
	a_class: assert property (p_class) else $error("class wrong");
	property p_two;
		dec_valid |-> is_two_word == two;
	endproperty
	a_two: assert property (p_two) else $error("two-word flag");
	property p_pair;
		dec_valid && is_two_word && word_valid |=>
			second_word_valid && !dec_valid && second_word == $past(word_in);
	endproperty
	a_pair: assert property (p_pair) else $error("second word");
	property p_answer;
		dec_valid || second_word_valid |-> $past(word_valid);
	endproperty
	a_answer: assert property (p_answer) else $error("no cause");
	property p_nop;
		dec_valid |-> is_nop == (op == OP_NOP);
	endproperty
	a_nop: assert property (p_nop) else $error("nop flag");
	property p_cyc;
		dec_valid |-> exec_cycles == ((two || (op >= 8'h30 && op <= 8'h37)
			|| (c_q && op >= 8'ha4 && op <= 8'ha7)) ? 2'h2 : 2'h1);
	endproperty
	a_cyc: assert property (p_cyc) else $error("cycles");
	property p_regs;
		dec_valid |-> base_source_reg == w_q[18:15] &&
			modifiable_source_reg == w_q[3:0] && result_dest_reg == w_q[10:7];
	endproperty
	a_regs: assert property (p_regs) else $error("reg fields");
	property p_file;
		dec_valid && op[7:4] == 4'hb |-> file_addr == w_q[12:0] &&
			dest_is_file == w_q[13] && dest_is_work_zero == !w_q[13];
	endproperty
	a_file: assert property (p_file) else $error("file fields");
	property p_lit;
		dec_valid |-> literal ==
			(op[7:4] == 4'h2 ? w_q[19:4] : {6'h00, w_q[13:4]});
	endproperty
	a_lit: assert property (p_lit) else $error("literal");
	property p_mac;
		dec_valid |-> acc_sel == w_q[15] &&
			acc_writeback == (op[7:3] == 5'h18 ? w_q[1:0] : 2'h0);
	endproperty
	a_mac: assert property (p_mac) else $error("accumulator");
	property p_hold;
		!dec_valid |-> $stable(literal) && $stable(insn_class);
	endproperty
	a_hold: assert property (p_hold) else $error("not held");
endmodule
bind insn_format_decode insn_format_sva #(.WORD_WIDTH(WORD_WIDTH)) chk_u (
	.clock, .reset_n, .word_valid, .word_in, .cond_true, .dec_valid,
	.insn_class, .is_nop, .is_two_word, .second_word_valid, .second_word,
	.exec_cycles, .base_source_reg, .modifiable_source_reg,
	.result_dest_reg, .file_addr, .dest_is_file, .dest_is_work_zero,
	.literal, .acc_sel, .acc_writeback);
`default_nettype wire

// File: sim/fetch_stage_model.sv
// behavioural fetch stage handing program words to the decoder
`default_nettype none
module fetch_stage_model (
	// clock
	input wire logic clock,
	// program word out
	output logic word_valid,
	output logic [23:0] word_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		word_valid = 1'b0;
		word_in = 24'h000000;
	end
	// one word per call, changed just after a falling edge
	task automatic send(input logic [23:0] w);
		@(negedge clock);
		word_valid = 1'b1;
		word_in = w;
	endtask
	// stale words are inverted so they never pass for a live one
	task automatic idle();
		@(negedge clock);
		word_valid = 1'b0;
		word_in = ~word_in;
	endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the instruction format decoder
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
	err_count++; $display("MISMATCH %s expected %0h seen %0h", n, e, a); \
	end end
module tb_top
	import insn_decode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset_n, cond_true, word_valid, dec_valid, is_nop;
	logic is_two_word, second_word_valid, dest_is_file, dest_is_work_zero;
	logic bit_pos_from_reg, acc_sel;
	logic [23:0] word_in, second_word;
	logic [1:0] exec_cycles, acc_writeback;
	logic [3:0] base_source_reg, modifiable_source_reg, result_dest_reg;
	logic [3:0] bit_pos, mul_pair, x_prefetch, y_prefetch, shift_count_reg;
	logic [2:0] source_mode, dest_mode;
	logic [12:0] file_addr;
	logic [15:0] literal;
	logic [5:0] shift_amount;
	insn_class_t insn_class;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	fetch_stage_model fetch_u (.clock, .word_valid, .word_in);
	insn_format_decode #(.WORD_WIDTH(24)) dut_u (.clock, .reset_n,
		.word_valid, .word_in, .cond_true, .dec_valid, .insn_class, .is_nop,
		.is_two_word, .second_word_valid, .second_word, .exec_cycles,
		.base_source_reg, .modifiable_source_reg, .source_mode,
		.result_dest_reg, .dest_mode, .file_addr, .dest_is_file,
		.dest_is_work_zero, .literal, .bit_pos, .bit_pos_from_reg, .acc_sel,
		.mul_pair, .x_prefetch, .y_prefetch, .acc_writeback, .shift_amount,
		.shift_count_reg);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ----
	// scenarios
	// ----
	task automatic dec(input logic [23:0] w);
		fetch_u.send(w);
		fetch_u.idle();
	endtask
	task automatic t_class();
		logic [7:0] ops [8] = '{8'h00, 8'h1c, 8'h24, 8'h45, 8'h91, 8'hb3,
			8'hc2, 8'hcb};
		logic [4:0] cls [8] = '{5'h10, 5'h10, 5'h04, 5'h01, 5'h02, 5'h01,
			5'h08, 5'h08};
		for (int i = 0; i < 8; i++) begin
			dec({ops[i], 16'h0010});
			`CHK("class", cls[i], insn_class)
			`CHK("nop", ops[i] == 8'h00, is_nop)
		end
		$display("test class done");
	endtask
	task automatic t_regs();
		logic [23:0] w = 24'h47a5b3;
		dec(w);
		`CHK("base", w[18:15], base_source_reg)
		`CHK("src", w[6:0], {source_mode, modifiable_source_reg})
		`CHK("dst", w[13:7], {dest_mode, result_dest_reg})
		`CHK("lit", {6'h00, w[13:4]}, literal)
		repeat (3) fetch_u.idle();
		`CHK("held", w[18:15], base_source_reg)
		$display("test regs done");
	endtask
	task automatic t_file_bit();
		for (int b = 0; b < 2; b++) begin
			dec({8'hb4, 2'b00, b[0], 13'h1abc});
			`CHK("faddr", 13'h1abc, file_addr)
			`CHK("tofile", b[0], dest_is_file)
			`CHK("towz", !b[0], dest_is_work_zero)
			dec({12'h9c3, 5'h00, b[0], 6'h05});
			`CHK("bitpos", 4'h3, bit_pos)
			`CHK("bitreg", b[0], bit_pos_from_reg)
		end
		$display("test file and bit done");
	endtask
	task automatic t_lit_dsp();
		dec(24'h2abcd5);
		`CHK("litmov", 16'hbcd5 >> 4 | 16'ha000, literal)
		dec(24'hc5d7a6);
		`CHK("mac", 15'h77a6, {acc_sel, mul_pair, x_prefetch, y_prefetch,
			acc_writeback})
		dec(24'hca8d9f);
		`CHK("byreg", 10'h00f, {shift_amount, shift_count_reg})
		dec(24'hca8d8f);
		`CHK("bylit", 10'h1b0, {shift_amount, shift_count_reg})
		`CHK("acc", 1'b1, acc_sel)
		$display("test literal and dsp done");
	endtask
	task automatic t_two();
		logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
		for (int i = 0; i < 3; i++) begin
			fetch_u.send({ops[i], 16'h0000});
			fetch_u.send(24'h000120 + i);
			`CHK("two", 4'he, {dec_valid, is_two_word, exec_cycles})
			fetch_u.idle();
			`CHK("second", 24'h000120 + i, second_word)
			`CHK("pulse", 2'h2, {second_word_valid, dec_valid})
		end
		$display("test two-word done");
	endtask
	task automatic t_cyc();
		logic [7:0] ops [4] = '{8'h32, 8'ha5, 8'ha5, 8'h41};
		logic cnd [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		logic [1:0] exp [4] = '{2'h2, 2'h2, 2'h1, 2'h1};
		for (int i = 0; i < 4; i++) begin
			cond_true = cnd[i];
			dec({ops[i], 16'h0000});
			`CHK("cycles", exp[i], exec_cycles)
		end
		$display("test cycles done");
	endtask
	task automatic t_reset();
		dec(24'h2fffff);
		reset_n = 1'b0;
		#10;
		`CHK("rst", 4'h5, {dec_valid, is_nop, exec_cycles})
		`CHK("rcls", 5'h10, insn_class)
		`CHK("rlit", 16'h0000, literal)
		@(negedge clock);
		reset_n = 1'b1;
		repeat (2) @(negedge clock);
		dec(24'h2fffff);
		`CHK("third", 17'h1ffff, {dec_valid, literal})
		$display("test reset done");
	endtask
	// ----
	// verdict
	// ----
	task automatic final_report();
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// the whole run needs about 65 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		reset_n = 1'b0;
		cond_true = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		repeat (2) @(negedge clock);
		t_class();
		t_regs();
		t_file_bit();
		t_lit_dsp();
		t_two();
		t_cyc();
		t_reset();
		final_report();
	end
endmodule
`default_nettype wire
